// File: src/epbuf_pkg.sv
package epbuf_pkg;
    // ****************************************************************
    // Register map
    // ****************************************************************
    localparam logic [7:0] ADDR_DATA_PORT = 8'h20;
    localparam logic [7:0] ADDR_BUF_CTRL = 8'h28;
    localparam logic [7:0] ADDR_INDEX = 8'h2C;
    localparam logic [7:0] ADDR_MAXPKT = 8'h04;
    localparam logic [7:0] ADDR_EPSTAT = 8'h30;
    // ****************************************************************
    // Field positions
    // ****************************************************************
    localparam int IDX_DIR_BIT = 0;
    localparam int IDX_EPNUM_LSB = 1;
    localparam int IDX_SETUP_BIT = 5;
    localparam int CTL_STALL_BIT = 0;
    localparam int CTL_STATUS_BIT = 1;
    localparam int CTL_COMMIT_BIT = 3;
    localparam int CTL_FLUSH_BIT = 4;
    localparam logic [7:0] INDEX_MASK = 8'h3F;
    localparam logic [7:0] CTRL_MASK = 8'h1B;
    localparam logic [7:0] INDEX_RESET = 8'h00;
    localparam logic [7:0] CTRL_RESET = 8'h00;
    localparam logic [7:0] MAXPKT_RESET = 8'h40;
    // ****************************************************************
    // Endpoint kinds
    // ****************************************************************
    typedef enum logic [1:0] {
        EP_CONTROL = 2'h0,
        EP_ISO = 2'h1,
        EP_BULK = 2'h2,
        EP_INT = 2'h3
    } ep_kind_type;
endpackage : epbuf_pkg

// File: src/ep_slot.sv
`timescale 1ns/100ps
// One buffer of one endpoint: byte count, ready flag and storage
module ep_slot #(
    parameter int DEPTH = 64,
    parameter int CW = 7
) (
    input wire logic clk,
    input wire logic rst_b,
    input wire logic sel,
    input wire logic is_tx,
    input wire logic [CW-1:0] maxpkt,
    input wire logic cpu_wr,
    input wire logic cpu_rd,
    input wire logic [7:0] cpu_wdata,
    input wire logic flush,
    input wire logic commit,
    input wire logic usb_wr,
    input wire logic usb_done,
    input wire logic [7:0] usb_wdata,
    output logic [7:0] rdata,
    output logic [CW-1:0] count_r,
    output logic ready_r
);
    logic [7:0] mem [DEPTH];
    logic [CW-1:0] ptr_r;
    logic [CW-1:0] count_nxt;
    logic do_wr;
    logic do_rd;

    assign do_wr = sel & cpu_wr & is_tx & ~ready_r & (count_r < maxpkt);
    assign do_rd = sel & cpu_rd & ~is_tx & ready_r & (count_r != '0);
    assign rdata = mem[ptr_r[$clog2(DEPTH)-1:0]];
    assign count_nxt = count_r - CW'(1);

    always_ff @(posedge clk) begin
        if (do_wr) begin
            mem[count_r[$clog2(DEPTH)-1:0]] <= cpu_wdata;
        end else if (usb_wr && !is_tx && !ready_r) begin
            mem[count_r[$clog2(DEPTH)-1:0]] <= usb_wdata;
        end
    end

    always_ff @(posedge clk or negedge rst_b) begin
        if (!rst_b) begin
            count_r <= '0;
            ptr_r <= '0;
            ready_r <= 1'b0;
        end else if (sel && flush && !is_tx) begin
            count_r <= '0;
            ptr_r <= '0;
            ready_r <= 1'b0;
        end else if (do_rd) begin
            count_r <= count_nxt;
            ptr_r <= ptr_r + CW'(1);
            ready_r <= (count_nxt != '0);
        end else if (do_wr) begin
            count_r <= count_r + CW'(1);
            ready_r <= ((count_r + CW'(1)) == maxpkt);
        end else if (sel && commit && is_tx) begin
            ready_r <= 1'b1;
        end else if (usb_done) begin
            ready_r <= ~is_tx & (count_r != '0);
            if (is_tx) begin
                count_r <= '0;
            end
            ptr_r <= '0;
        end else if (usb_wr && !is_tx && !ready_r) begin
            count_r <= count_r + CW'(1);
        end
    end
endmodule : ep_slot

// File: src/usb_endpoint_index_buffer_ctrl.sv
// Implementation choice: the plain strobed port.
`timescale 1ns/100ps
// Behaviour
// - One-byte index steers all indexed registers
// - Index combines endpoint number and direction
// - Four-bit endpoint number field selects endpoint
// - Setup select routes endpoint 0 to SETUP
// - Direction zero RX, one TX
// - Endpoint 0 buffer addressing table
// - Flush bit empties indexed RX only
// - RX empties after full read
// - Commit bit readies short TX packet
// - TX readies at max packet size
// - Status bit picks NAK or ACK/ZLP
// - Status bit clears at end/SETUP
// - Stall bit stalls, ignored for isochronous
// - Data port reaches selected FIFO
module usb_endpoint_index_buffer_ctrl
    import epbuf_pkg::*;
#(
    parameter int NUM_EP = 4,
    parameter int DEPTH = 64,
    parameter int CW = 7
) (
    input wire logic CLK_SYS,
    input wire logic RST_B,
    input wire logic BUS_RESET,
    input wire logic [7:0] ADDR,
    input wire logic [7:0] WDATA,
    input wire logic WR,
    input wire logic RD,
    output logic [7:0] RDATA,
    input wire logic [NUM_EP*2-1:0] EP_TYPE,
    input wire logic SETUP_TOKEN,
    input wire logic STATUS_DONE,
    input wire logic [3:0] USB_EP,
    input wire logic USB_DIR,
    input wire logic USB_SETUP_BUF,
    input wire logic USB_WR,
    input wire logic [7:0] USB_WDATA,
    input wire logic USB_DONE,
    output logic [NUM_EP*2:0] BUF_READY,
    output logic [NUM_EP-1:0] EP_STALL,
    output logic STATUS_ACK
);
    import epbuf_pkg::*;
    localparam int NS = NUM_EP * 2 + 1;

    logic [7:0] index_r;
    logic [7:0] ctrl_r;
    logic [CW-1:0] maxpkt_r;
    logic [7:0] rdata_nxt;
    logic [3:0] ep_num;
    logic dir;
    logic setup_sel;
    logic [NS-1:0] slot_sel;
    logic [NS-1:0] slot_usb;
    logic [7:0] slot_rdata [NS];
    logic [CW-1:0] slot_count [NS];
    logic [NS-1:0] slot_ready;
    logic wr_ctrl;
    logic wr_index;
    logic cmd_flush;
    logic cmd_commit;
    logic sel_iso;
    logic sel_ctl;
    logic slot_rst_b_r;
    logic [$clog2(NUM_EP)-1:0] ep_low;

    // ****************************************************************
    // Index decode
    // ****************************************************************
    // endpoint number field
    assign ep_num = index_r[IDX_EPNUM_LSB +: 4];
    assign dir = index_r[IDX_DIR_BIT];
    assign setup_sel = index_r[IDX_SETUP_BIT];
    assign wr_ctrl = WR && (ADDR == ADDR_BUF_CTRL);
    assign wr_index = WR && (ADDR == ADDR_INDEX);
    assign cmd_flush = wr_ctrl && WDATA[CTL_FLUSH_BIT];
    assign cmd_commit = wr_ctrl && WDATA[CTL_COMMIT_BIT];
    assign sel_iso = (ep_num < 4'(NUM_EP)) &&
        (EP_TYPE[ep_num[$clog2(NUM_EP)-1:0]*2 +: 2] == EP_ISO);
    assign sel_ctl = (ep_num < 4'(NUM_EP)) &&
        (EP_TYPE[ep_num[$clog2(NUM_EP)-1:0]*2 +: 2] == EP_CONTROL);
    assign ep_low = ep_num[$clog2(NUM_EP)-1:0];

    // Slot 0 is the SETUP buffer, then RX/TX pairs per endpoint
    // index steers selection
    always_comb begin
        slot_sel = '0;
        slot_usb = '0;
        if (setup_sel && ep_num == 4'h0 && !dir) begin
            slot_sel[0] = 1'b1;
        end else if (ep_num < 4'(NUM_EP)) begin
            slot_sel[1 + ep_num * 2 + dir] = 1'b1;
        end
        if (USB_SETUP_BUF) begin
            slot_usb[0] = 1'b1;
        end else if (USB_EP < 4'(NUM_EP)) begin
            slot_usb[1 + USB_EP * 2 + USB_DIR] = 1'b1;
        end
    end

    genvar g;
    generate
        for (g = 0; g < NS; g++) begin : g_slot
            ep_slot #(.DEPTH(DEPTH), .CW(CW)) u_slot (
                .clk(CLK_SYS),
                .rst_b(slot_rst_b_r),
                .sel(slot_sel[g]),
                .is_tx(g != 0 && ((g - 1) % 2) == 1),
                .maxpkt(maxpkt_r),
                .cpu_wr(WR && ADDR == ADDR_DATA_PORT),
                .cpu_rd(RD && ADDR == ADDR_DATA_PORT),
                .cpu_wdata(WDATA),
                .flush(cmd_flush),
                .commit(cmd_commit),
                .usb_wr(USB_WR && slot_usb[g]),
                .usb_done(USB_DONE && slot_usb[g]),
                .usb_wdata(USB_WDATA),
                .rdata(slot_rdata[g]),
                .count_r(slot_count[g]),
                .ready_r(slot_ready[g])
            );
        end
    endgenerate

    // ****************************************************************
    // Registers
    // ****************************************************************
    // Bus reset reaches the slots from a flop; a gated reset could glitch
    always_ff @(posedge CLK_SYS or negedge RST_B) begin
        if (!RST_B) begin
            slot_rst_b_r <= 1'b0;
        end else begin
            slot_rst_b_r <= ~BUS_RESET;
        end
    end

    always_ff @(posedge CLK_SYS or negedge RST_B) begin
        if (!RST_B) begin
            index_r <= INDEX_RESET;
        end else if (wr_index) begin
            index_r <= WDATA & INDEX_MASK;
        end
    end

    always_ff @(posedge CLK_SYS or negedge RST_B) begin
        if (!RST_B) begin
            maxpkt_r <= CW'(MAXPKT_RESET);
        end else if (WR && ADDR == ADDR_MAXPKT) begin
            maxpkt_r <= WDATA[CW-1:0];
        end
    end

    // Flush and commit are self-clearing actions; status and stall persist
    // control clears on both resets
    always_ff @(posedge CLK_SYS or negedge RST_B) begin
        if (!RST_B) begin
            ctrl_r <= CTRL_RESET;
        end else if (BUS_RESET) begin
            ctrl_r <= CTRL_RESET;
        end else begin
            if (wr_ctrl && sel_ctl) begin
                ctrl_r[CTL_STATUS_BIT] <= WDATA[CTL_STATUS_BIT];
            end else if (SETUP_TOKEN || STATUS_DONE) begin
                ctrl_r[CTL_STATUS_BIT] <= 1'b0;
            end
            ctrl_r[CTL_FLUSH_BIT] <= 1'b0;
            ctrl_r[CTL_COMMIT_BIT] <= 1'b0;
        end
    end

    always_ff @(posedge CLK_SYS or negedge RST_B) begin
        if (!RST_B) begin
            EP_STALL <= '0;
        end else if (BUS_RESET) begin
            EP_STALL <= '0;
        end else if (wr_ctrl && ep_num < 4'(NUM_EP)) begin
            EP_STALL[ep_num[$clog2(NUM_EP)-1:0]] <= WDATA[CTL_STALL_BIT] & ~sel_iso;
        end
    end

    always_ff @(posedge CLK_SYS or negedge RST_B) begin
        if (!RST_B) begin
            STATUS_ACK <= 1'b0;
        end else begin
            STATUS_ACK <= ctrl_r[CTL_STATUS_BIT];
        end
    end

    always_ff @(posedge CLK_SYS or negedge RST_B) begin
        if (!RST_B) begin
            BUF_READY <= '0;
        end else begin
            BUF_READY <= slot_ready;
        end
    end

    // ****************************************************************
    // Read mux
    // ****************************************************************
    always_comb begin
        rdata_nxt = 8'h00;
        if (ADDR == ADDR_INDEX) begin
            rdata_nxt = index_r;
        end else if (ADDR == ADDR_BUF_CTRL) begin
            rdata_nxt = ctrl_r & CTRL_MASK;
            if (ep_num < 4'(NUM_EP)) begin
                rdata_nxt[CTL_STALL_BIT] = EP_STALL[ep_num[$clog2(NUM_EP)-1:0]];
            end
        end else if (ADDR == ADDR_MAXPKT) begin
            rdata_nxt = 8'(maxpkt_r);
        end else if (ADDR == ADDR_DATA_PORT) begin
            for (int s = 0; s < NS; s++) begin
                if (slot_sel[s]) begin
                    rdata_nxt = slot_rdata[s];
                end
            end
        end else if (ADDR == ADDR_EPSTAT) begin
            for (int s = 0; s < NS; s++) begin
                if (slot_sel[s]) begin
                    rdata_nxt = {slot_ready[s], 7'(slot_count[s])};
                end
            end
        end
    end

    always_ff @(posedge CLK_SYS or negedge RST_B) begin
        if (!RST_B) begin
            RDATA <= 8'h00;
        end else if (RD) begin
            RDATA <= rdata_nxt;
        end else begin
            RDATA <= 8'h00;
        end
    end

    // ****************************************************************
    // Checks
    // ****************************************************************
    property p_index_wr;
        @(posedge CLK_SYS) disable iff (!RST_B)
        wr_index |=> index_r == ($past(WDATA) & INDEX_MASK);
    endproperty
    a_index_wr: assert property (p_index_wr) else $error("index not stored");

    property p_busrst_keeps_index;
        @(posedge CLK_SYS) disable iff (!RST_B)
        (BUS_RESET && !wr_index) |=> $stable(index_r);
    endproperty
    a_busrst_keeps_index: assert property (p_busrst_keeps_index) else $error("index lost");

    property p_status_clear;
        @(posedge CLK_SYS) disable iff (!RST_B)
        ((SETUP_TOKEN || STATUS_DONE) && !wr_ctrl) |=> !ctrl_r[CTL_STATUS_BIT];
    endproperty
    a_status_clear: assert property (p_status_clear) else $error("status not cleared");

    property p_status_out;
        @(posedge CLK_SYS) disable iff (!RST_B)
        ctrl_r[CTL_STATUS_BIT] |=> STATUS_ACK;
    endproperty
    a_status_out: assert property (p_status_out) else $error("status reply wrong");

    property p_iso_nostall;
        @(posedge CLK_SYS) disable iff (!RST_B)
        (wr_ctrl && sel_iso && !BUS_RESET) |=> !EP_STALL[$past(ep_low)];
    endproperty
    a_iso_nostall: assert property (p_iso_nostall) else $error("iso stalled");

    property p_ep0_setup;
        @(posedge CLK_SYS) disable iff (!RST_B)
        (index_r == 8'h20) |-> slot_sel[0];
    endproperty
    a_ep0_setup: assert property (p_ep0_setup) else $error("setup route wrong");

    property p_ep1_rx;
        @(posedge CLK_SYS) disable iff (!RST_B)
        (index_r == 8'h02 && NUM_EP > 1) |-> slot_sel[3];
    endproperty
    a_ep1_rx: assert property (p_ep1_rx) else $error("endpoint 1 rx route wrong");

    property p_flush;
        @(posedge CLK_SYS) disable iff (!RST_B)
        (cmd_flush && !dir && slot_sel != '0) |=> ((slot_ready & $past(slot_sel)) == '0);
    endproperty
    a_flush: assert property (p_flush) else $error("rx not flushed");

    property p_commit;
        @(posedge CLK_SYS) disable iff (!RST_B)
        (cmd_commit && dir && slot_sel != '0 && slot_rst_b_r && !BUS_RESET) |=>
            ((slot_ready & $past(slot_sel)) != '0);
    endproperty
    a_commit: assert property (p_commit) else $error("tx not committed");

    property p_stall_set;
        @(posedge CLK_SYS) disable iff (!RST_B)
        (wr_ctrl && WDATA[CTL_STALL_BIT] && !sel_iso && ep_num < 4'(NUM_EP) && !BUS_RESET) |=>
            EP_STALL[$past(ep_low)];
    endproperty
    a_stall_set: assert property (p_stall_set) else $error("endpoint not stalled");

    property p_rdata_idle;
        @(posedge CLK_SYS) disable iff (!RST_B)
        !RD |=> (RDATA == 8'h00);
    endproperty
    a_rdata_idle: assert property (p_rdata_idle) else $error("read data not idle");
endmodule : usb_endpoint_index_buffer_ctrl

// File: sim/usb_engine_model.sv
`timescale 1ns/100ps
// ****
// Packet engine stand-in
// ****
module usb_engine_model (
    input wire logic clk,
    output logic [3:0] usb_ep,
    output logic usb_dir,
    output logic usb_setup_buf,
    output logic usb_wr,
    output logic [7:0] usb_wdata,
    output logic usb_done,
    output logic setup_token,
    output logic status_done
);
    initial begin
        usb_ep = 4'h0;
        usb_dir = 1'b0;
        usb_setup_buf = 1'b0;
        usb_wr = 1'b0;
        usb_wdata = 8'h00;
        usb_done = 1'b0;
        setup_token = 1'b0;
        status_done = 1'b0;
    end
    // Idle data wanders so a stale byte is never taken for a load
    always @(negedge clk) begin
        if (!usb_wr) begin
            usb_wdata <= ~usb_wdata;
        end
    end
    // An empty queue with dir 1 reports an IN packet sent
    task automatic send(input logic [3:0] ep, input logic dir, input logic setup, input logic [7:0] d[$]);
        foreach (d[i]) begin
            @(posedge clk);
            usb_ep <= ep;
            usb_dir <= dir;
            usb_setup_buf <= setup;
            usb_wr <= 1'b1;
            usb_wdata <= d[i];
        end
        @(posedge clk);
        usb_ep <= ep;
        usb_dir <= dir;
        usb_wr <= 1'b0;
        usb_done <= 1'b1;
        @(posedge clk);
        usb_done <= 1'b0;
    endtask : send
    task automatic token(input logic is_setup);
        @(posedge clk);
        setup_token <= is_setup;
        status_done <= !is_setup;
        @(posedge clk);
        setup_token <= 1'b0;
        status_done <= 1'b0;
    endtask : token
endmodule : usb_engine_model

// File: sim/test_usb_endpoint_index_buffer_ctrl.sv
`timescale 1ns/100ps
`define CHK(g, e) begin checks++; if ((g) !== (e)) begin n_mismatch++; \
    $display("CHECK FAILED t=%0t got %h exp %h", $time, g, e); end end
module test_usb_endpoint_index_buffer_ctrl;
    import epbuf_pkg::*;
    localparam logic [7:0] IX_T [4] = '{8'h20, 8'h00, 8'h02, 8'h06};
    logic CLK_SYS, RST_B, BUS_RESET, WR, RD, SETUP_TOKEN, STATUS_DONE;
    logic USB_DIR, USB_SETUP_BUF, USB_WR, USB_DONE, STATUS_ACK;
    logic [7:0] ADDR, WDATA, RDATA, EP_TYPE, USB_WDATA, v;
    logic [3:0] USB_EP, EP_STALL;
    logic [8:0] BUF_READY;
    logic [7:0] q[$];
    logic [7:0] none[$];
    int n_mismatch, checks, seed;
    usb_endpoint_index_buffer_ctrl #(.NUM_EP(4), .DEPTH(64), .CW(7)) uut (.CLK_SYS(CLK_SYS), .RST_B(RST_B),
        .BUS_RESET(BUS_RESET), .ADDR(ADDR), .WDATA(WDATA), .WR(WR), .RD(RD), .RDATA(RDATA), .EP_TYPE(EP_TYPE),
        .SETUP_TOKEN(SETUP_TOKEN), .STATUS_DONE(STATUS_DONE), .USB_EP(USB_EP), .USB_DIR(USB_DIR),
        .USB_SETUP_BUF(USB_SETUP_BUF), .USB_WR(USB_WR), .USB_WDATA(USB_WDATA), .USB_DONE(USB_DONE),
        .BUF_READY(BUF_READY), .EP_STALL(EP_STALL), .STATUS_ACK(STATUS_ACK));
    usb_engine_model eng (.clk(CLK_SYS), .usb_ep(USB_EP), .usb_dir(USB_DIR), .usb_setup_buf(USB_SETUP_BUF),
        .usb_wr(USB_WR), .usb_wdata(USB_WDATA), .usb_done(USB_DONE), .setup_token(SETUP_TOKEN),
        .status_done(STATUS_DONE));
    // ****
    // Bus tasks and expectations
    // ****
    function automatic int rdy_bit(input logic [7:0] ix);
        return ix[IDX_SETUP_BIT] ? 0 : 1 + 2 * int'(ix[4:1]) + int'(ix[IDX_DIR_BIT]);
    endfunction : rdy_bit
    task automatic conclude();
        if (n_mismatch == 0 && checks > 0) begin
            $display("ALL CHECKS OK");
        end else begin
            $display("CHECKS NOT OK");
        end
        $finish;
    endtask : conclude
    task automatic settle();
        @(posedge CLK_SYS);
        #1;
    endtask : settle
    task automatic wr(input logic [7:0] a, input logic [7:0] d);
        ADDR <= a;
        WDATA <= d;
        WR <= 1'b1;
        @(posedge CLK_SYS);
        WR <= 1'b0;
        @(posedge CLK_SYS);
    endtask : wr
    task automatic rd_chk(input logic [7:0] a, input logic [7:0] e);
        ADDR <= a;
        RD <= 1'b1;
        @(posedge CLK_SYS);
        RD <= 1'b0;
        #1;
        `CHK(RDATA, e)
        @(posedge CLK_SYS);
    endtask : rd_chk
    task automatic wait_rdy(input int b, input logic e);
        int n;
        n = 0;
        while (BUF_READY[b] !== e && n < 20) begin
            settle();
            n++;
        end
        `CHK(BUF_READY[b], e)
        if (n == 20) begin
            conclude();
        end
    endtask : wait_rdy
    task automatic mk_pkt(input int n);
        q.delete();
        repeat (n) q.push_back(8'($urandom));
    endtask : mk_pkt
    initial begin
        CLK_SYS = 1'b0;
        forever #2.5 CLK_SYS = ~CLK_SYS;
    end
    initial begin
        repeat (20000) @(posedge CLK_SYS);
        n_mismatch++;
        conclude();
    end
    // ****
    // Scenarios
    // ****
    initial begin
        {RST_B, BUS_RESET, WR, RD, ADDR, WDATA} = '0;
        EP_TYPE = 8'hD8;
        n_mismatch = 0;
        checks = 0;
        seed = $urandom(46317);
        repeat (8) @(posedge CLK_SYS);
        RST_B <= 1'b1;
        @(posedge CLK_SYS);
        rd_chk(ADDR_INDEX, INDEX_RESET);
        rd_chk(ADDR_BUF_CTRL, CTRL_RESET);
        rd_chk(ADDR_MAXPKT, MAXPKT_RESET);
        rd_chk(8'h10, 8'h00);
        for (int i = 0; i < 6; i++) begin
            v = (i == 0) ? 8'hFF : 8'($urandom);
            // setup select on endpoint 0 only
            if (v[4:1] != 4'h0) v[IDX_SETUP_BIT] = 1'b0;
            wr(ADDR_INDEX, v);
            rd_chk(ADDR_INDEX, v & INDEX_MASK);
        end
        // Setup select only ever set with endpoint 0
        for (int k = 0; k < 4; k++) begin
            mk_pkt(1 + $urandom_range(7));
            eng.send(IX_T[k][4:1], 1'b0, IX_T[k][IDX_SETUP_BIT], q);
            wait_rdy(rdy_bit(IX_T[k]), 1'b1);
            wr(ADDR_INDEX, IX_T[k]);
            foreach (q[i]) rd_chk(ADDR_DATA_PORT, q[i]);
            wait_rdy(rdy_bit(IX_T[k]), 1'b0);
        end
        wr(ADDR_INDEX, 8'h03);
        mk_pkt(3);
        foreach (q[i]) wr(ADDR_DATA_PORT, q[i]);
        wait_rdy(4, 1'b0);
        wr(ADDR_BUF_CTRL, 8'h08);
        wait_rdy(4, 1'b1);
        mk_pkt(5);
        eng.send(4'h1, 1'b0, 1'b0, q);
        wait_rdy(3, 1'b1);
        wr(ADDR_INDEX, 8'h02);
        wr(ADDR_BUF_CTRL, 8'h10);
        wait_rdy(3, 1'b0);
        `CHK(BUF_READY[4], 1'b1)
        rd_chk(ADDR_BUF_CTRL, 8'h00);
        eng.send(4'h1, 1'b1, 1'b0, none);
        wait_rdy(4, 1'b0);
        wr(ADDR_MAXPKT, 8'h04);
        wr(ADDR_INDEX, 8'h05);
        mk_pkt(4);
        foreach (q[i]) begin
            wr(ADDR_DATA_PORT, q[i]);
            #1;
            `CHK(BUF_READY[6], 1'(i == 3))
        end
        rd_chk(ADDR_EPSTAT, 8'h84);
        wr(ADDR_INDEX, 8'h01);
        for (int k = 0; k < 2; k++) begin
            wr(ADDR_BUF_CTRL, 8'h02);
            #1;
            `CHK(STATUS_ACK, 1'b1)
            eng.token(k[0]);
            settle();
            `CHK(STATUS_ACK, 1'b0)
        end
        wr(ADDR_INDEX, 8'h02);
        wr(ADDR_BUF_CTRL, 8'h01);
        wr(ADDR_INDEX, 8'h04);
        wr(ADDR_BUF_CTRL, 8'h01);
        settle();
        `CHK(EP_STALL, 4'h2)
        wr(ADDR_INDEX, 8'h07);
        wr(ADDR_BUF_CTRL, 8'h02);
        settle();
        `CHK(STATUS_ACK, 1'b0)
        wr(ADDR_INDEX, 8'h01);
        wr(ADDR_BUF_CTRL, 8'h02);
        BUS_RESET <= 1'b1;
        @(posedge CLK_SYS);
        BUS_RESET <= 1'b0;
        settle();
        `CHK(EP_STALL, 4'h0)
        `CHK(STATUS_ACK, 1'b0)
        `CHK(BUF_READY, 9'h000)
        rd_chk(ADDR_INDEX, 8'h01);
        rd_chk(ADDR_BUF_CTRL, 8'h00);
        conclude();
    end
endmodule : test_usb_endpoint_index_buffer_ctrl
